/* isfp_map.svh */
// Register map, field positions, keys and reset values of the flash programmer
`ifndef ISFP_MAP_SVH
`define ISFP_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define ISFP_OFS_ADDR_HI 8'hF4
`define ISFP_OFS_ADDR_LO 8'hF5
`define ISFP_OFS_DATA 8'hF6
`define ISFP_OFS_CTRL 8'hF7
// ****************************************
// Fields and reset values
// ****************************************
`define ISFP_CTRL_START_BIT 7
`define ISFP_RST_BYTE 8'h00
`define ISFP_RST_ADDR 16'h0000
// ****************************************
// Keys and geometry
// ****************************************
`define ISFP_KEY_A 8'h55
`define ISFP_KEY_B 8'hAA
`define ISFP_BLANK_BYTE 8'hFF
`define ISFP_FLASH_END 16'h4000
`define ISFP_MAX_PAGES 4'h8
`define ISFP_PAGE_BITS 9
`endif

/* isfp_pkg.sv */
// Types of the flash programmer
package isfp_pkg;
  // Flash function select
  typedef enum logic [1:0] {
    FN_PROGRAM = 2'h0,
    FN_PROTECT = 2'h1,
    FN_PAGE_ERASE = 2'h2,
    FN_CHIP_ERASE = 2'h3
  } isfp_func_t;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_BOOT_RD = 4'h1,
    ST_BOOT_WAIT = 4'h2,
    ST_IDLE = 4'h4,
    ST_RUN = 4'h8
  } isfp_state_t;
  // Unlock progress
  typedef enum logic [1:0] {
    UL_NONE = 2'h0,
    UL_ONE = 2'h1,
    UL_TWO = 2'h2,
    UL_OPEN = 2'h3
  } isfp_unlock_t;
endpackage

/* isfp_top.sv */
// In-system flash programming sequencer with boot entry and read protection
`timescale 1ns/1ps
`include "isfp_map.svh"
module isfp_top (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Special-function register port
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Configuration and straps
  input wire logic i_isp_enable,
  input wire logic [3:0] i_boot_pages,
  input wire logic i_prot_lock_nv,
  input wire logic i_p2_6,
  input wire logic i_p2_7,
  input wire logic i_p4_3,
  // Flash array side
  output logic o_fl_req,
  output logic [1:0] o_fl_func,
  output logic [15:0] o_fl_addr,
  output logic [7:0] o_fl_wdata,
  output logic [15:0] o_fl_keep_base,
  input wire logic i_fl_done,
  output logic o_fl_rd,
  input wire logic [7:0] i_fl_rdata,
  input wire logic i_fl_rvalid,
  // External read path
  input wire logic [7:0] i_ext_rdata,
  output logic [7:0] o_ext_rdata,
  // CPU side
  output logic o_pc_hold,
  output logic o_boot_isp,
  output logic [15:0] o_boot_vec,
  output logic o_boot_done
);

  // ****************************************
  // Helpers
  // ****************************************

  // First address of the boot-service area
  function automatic logic [15:0] boot_base(input logic [3:0] n);
    logic [15:0] b;
    b = `ISFP_FLASH_END;
    if (n != 4'h0 && n <= `ISFP_MAX_PAGES) begin
      b = `ISFP_FLASH_END - {3'h0, n, 9'h000};
    end
    return b;
  endfunction

  // Address lies in the guarded area
  function automatic logic in_boot(input logic [15:0] a, input logic [3:0] n);
    return a >= boot_base(n);
  endfunction

  // ****************************************
  // State
  // ****************************************

  isfp_pkg::isfp_state_t state_reg;
  isfp_pkg::isfp_unlock_t unlock_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_reg;
  logic [1:0] func_reg;
  logic prot_lock_reg;
  logic [15:0] target_addr;
  logic wr_hi;
  logic wr_lo;
  logic wr_data;
  logic wr_ctrl;
  logic start_try;
  logic launch;
  logic guarded;
  logic busy;

  // Decoded strobes
  assign wr_hi = i_sfr_wr && i_sfr_addr == `ISFP_OFS_ADDR_HI;
  assign wr_lo = i_sfr_wr && i_sfr_addr == `ISFP_OFS_ADDR_LO;
  assign wr_data = i_sfr_wr && i_sfr_addr == `ISFP_OFS_DATA;
  assign wr_ctrl = i_sfr_wr && i_sfr_addr == `ISFP_OFS_CTRL;
  assign target_addr = {addr_hi_reg, addr_lo_reg};
  assign busy = state_reg == isfp_pkg::ST_RUN;

  // Start request, honoured only when unlocked and enabled
  assign start_try = wr_ctrl && i_sfr_wdata[`ISFP_CTRL_START_BIT];
  assign launch = start_try && state_reg == isfp_pkg::ST_IDLE
    && unlock_reg == isfp_pkg::UL_OPEN && i_isp_enable;

  // Program and page erase inside the boot area start no operation and relock
  assign guarded = (i_sfr_wdata[1:0] == isfp_pkg::FN_PROGRAM
    || i_sfr_wdata[1:0] == isfp_pkg::FN_PAGE_ERASE)
    && in_boot(target_addr, i_boot_pages);

  // ****************************************
  // Register file
  // ****************************************

  // Address registers
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_hi_reg <= `ISFP_RST_BYTE;
      addr_lo_reg <= `ISFP_RST_BYTE;
    end else if (i_clk_en) begin
      if (wr_hi) begin
        addr_hi_reg <= i_sfr_wdata;
      end
      if (wr_lo) begin
        addr_lo_reg <= i_sfr_wdata;
      end
    end
  end

  // Data register, also the unlock key path
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data_reg <= `ISFP_RST_BYTE;
    end else if (i_clk_en && wr_data) begin
      data_reg <= i_sfr_wdata;
    end
  end

  // Function select, frozen while an operation runs
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      func_reg <= 2'h0;
    end else if (i_clk_en && wr_ctrl && !busy) begin
      func_reg <= i_sfr_wdata[1:0];
    end
  end

  // Unlock sequence tracker
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      unlock_reg <= isfp_pkg::UL_NONE;
    end else if (i_clk_en) begin
      if (busy && i_fl_done) begin
        unlock_reg <= isfp_pkg::UL_NONE;
      end else if (launch && guarded) begin
        unlock_reg <= isfp_pkg::UL_NONE;
      end else if (wr_data && unlock_reg != isfp_pkg::UL_OPEN) begin
        case (unlock_reg)
          isfp_pkg::UL_NONE: begin
            unlock_reg <= (i_sfr_wdata == `ISFP_KEY_A) ?
              isfp_pkg::UL_ONE : isfp_pkg::UL_NONE;
          end
          isfp_pkg::UL_ONE: begin
            unlock_reg <= (i_sfr_wdata == `ISFP_KEY_B) ? isfp_pkg::UL_TWO :
              (i_sfr_wdata == `ISFP_KEY_A) ? isfp_pkg::UL_ONE :
              isfp_pkg::UL_NONE;
          end
          isfp_pkg::UL_TWO: begin
            unlock_reg <= (i_sfr_wdata == `ISFP_KEY_A) ?
              isfp_pkg::UL_OPEN : isfp_pkg::UL_NONE;
          end
          default: begin
            unlock_reg <= isfp_pkg::UL_NONE;
          end
        endcase
      end
    end
  end

  // Registered read data
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= `ISFP_RST_BYTE;
    end else if (i_clk_en && i_sfr_rd) begin
      case (i_sfr_addr)
        `ISFP_OFS_ADDR_HI: begin
          o_sfr_rdata <= addr_hi_reg;
        end
        `ISFP_OFS_ADDR_LO: begin
          o_sfr_rdata <= addr_lo_reg;
        end
        `ISFP_OFS_DATA: begin
          o_sfr_rdata <= data_reg;
        end
        `ISFP_OFS_CTRL: begin
          o_sfr_rdata <= {busy, 5'h00, func_reg};
        end
        default: begin
          o_sfr_rdata <= `ISFP_RST_BYTE;
        end
      endcase
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************

  // Boot read, then idle and run
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= isfp_pkg::ST_BOOT_RD;
    end else if (i_clk_en) begin
      case (state_reg)
        isfp_pkg::ST_BOOT_RD: begin
          state_reg <= isfp_pkg::ST_BOOT_WAIT;
        end
        isfp_pkg::ST_BOOT_WAIT: begin
          if (i_fl_rvalid) begin
            state_reg <= isfp_pkg::ST_IDLE;
          end
        end
        isfp_pkg::ST_IDLE: begin
          if (launch && !guarded) begin
            state_reg <= isfp_pkg::ST_RUN;
          end
        end
        isfp_pkg::ST_RUN: begin
          if (i_fl_done) begin
            state_reg <= isfp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= isfp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Operand latch and request pulse toward the array
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fl_req <= 1'b0;
      o_fl_func <= 2'h0;
      o_fl_addr <= `ISFP_RST_ADDR;
      o_fl_wdata <= `ISFP_RST_BYTE;
      o_fl_rd <= 1'b0;
    end else if (i_clk_en) begin
      o_fl_req <= 1'b0;
      o_fl_rd <= state_reg == isfp_pkg::ST_BOOT_RD;
      if (state_reg == isfp_pkg::ST_BOOT_RD) begin
        o_fl_addr <= `ISFP_RST_ADDR;
      end else if (launch && !guarded) begin
        o_fl_req <= 1'b1;
        o_fl_func <= i_sfr_wdata[1:0];
        o_fl_wdata <= data_reg;
        if (i_sfr_wdata[1:0] == isfp_pkg::FN_PAGE_ERASE) begin
          o_fl_addr <= {target_addr[15:`ISFP_PAGE_BITS], 9'h000};
        end else begin
          o_fl_addr <= target_addr;
        end
      end
    end
  end

  // Chip erase keeps everything from the boot base upward
  assign o_fl_keep_base = boot_base(i_boot_pages);

  // Program counter stall while the array works
  assign o_pc_hold = busy;

  // ****************************************
  // Read protection
  // ****************************************

  // Lock: zero means protected
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prot_lock_reg <= 1'b1;
    end else if (i_clk_en) begin
      if (state_reg == isfp_pkg::ST_BOOT_RD) begin
        prot_lock_reg <= i_prot_lock_nv;
      end else if (busy && i_fl_done) begin
        if (o_fl_func == isfp_pkg::FN_CHIP_ERASE) begin
          prot_lock_reg <= 1'b1;
        end else if (o_fl_func == isfp_pkg::FN_PROTECT) begin
          prot_lock_reg <= 1'b0;
        end
      end
    end
  end

  // External reads masked to zero while protected
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_rdata <= `ISFP_RST_BYTE;
    end else if (i_clk_en) begin
      o_ext_rdata <= prot_lock_reg ? i_ext_rdata : `ISFP_RST_BYTE;
    end
  end

  // ****************************************
  // Boot entry
  // ****************************************

  // Blank first byte or straps select the boot area
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_boot_isp <= 1'b0;
      o_boot_vec <= `ISFP_RST_ADDR;
      o_boot_done <= 1'b0;
    end else if (i_clk_en && state_reg == isfp_pkg::ST_BOOT_WAIT && i_fl_rvalid) begin
      o_boot_done <= 1'b1;
      if (i_fl_rdata == `ISFP_BLANK_BYTE || (!i_p2_6 && !i_p2_7) || !i_p4_3) begin
        o_boot_isp <= 1'b1;
        o_boot_vec <= boot_base(i_boot_pages);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_key_a;
    i_clk_en && wr_data && i_sfr_wdata == `ISFP_KEY_A;
  endsequence
  sequence s_key_b;
    i_clk_en && wr_data && i_sfr_wdata == `ISFP_KEY_B;
  endsequence
  sequence s_unlock;
    s_key_a ##1 (s_key_b and (unlock_reg == isfp_pkg::UL_ONE)) ##1 s_key_a;
  endsequence

  a_unlock_opens: assert property (
    (unlock_reg == isfp_pkg::UL_NONE && !busy) ##0 s_unlock |=>
      unlock_reg == isfp_pkg::UL_OPEN)
    else $error("unlock sequence did not open start bit");

  a_locked_ignore: assert property (
    i_clk_en && start_try && unlock_reg != isfp_pkg::UL_OPEN && !busy
      |=> !busy && !o_fl_req)
    else $error("start accepted without unlock");

  a_launch_req: assert property (
    i_clk_en && launch && !guarded |=> o_fl_req && o_pc_hold)
    else $error("launch gave no request");

  a_guard_skip: assert property (
    i_clk_en && launch && guarded |=> !o_fl_req [*2])
    else $error("guarded area was touched");

  a_page_align: assert property (
    o_fl_req && o_fl_func == isfp_pkg::FN_PAGE_ERASE |-> o_fl_addr[8:0] == 9'h000)
    else $error("page erase address not page aligned");

  a_done_release: assert property (
    i_clk_en && busy && i_fl_done |=> !o_pc_hold && unlock_reg == isfp_pkg::UL_NONE)
    else $error("completion did not release cpu and relock");

  a_erase_unprot: assert property (
    i_clk_en && busy && i_fl_done && o_fl_func == isfp_pkg::FN_CHIP_ERASE
      |=> prot_lock_reg)
    else $error("chip erase left flash protected");

  a_protect_zero: assert property (
    i_clk_en && !prot_lock_reg |=> o_ext_rdata == 8'h00)
    else $error("protected flash read not zero");

  a_boot_blank: assert property (
    i_clk_en && state_reg == isfp_pkg::ST_BOOT_WAIT && i_fl_rvalid
      && i_fl_rdata == 8'hFF |=> o_boot_isp && o_boot_done)
    else $error("blank first byte did not select boot area");

endmodule

/* isfp_flash_model.sv */
// Behavioural flash array answering the programming sequencer
`timescale 1ns/1ps
module isfp_flash_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Sequencer requests
  input wire logic i_fl_req,
  input wire logic i_fl_rd,
  // Bench controls
  input wire logic [7:0] i_first_byte,
  input wire logic [4:0] i_lat,
  // Answers
  output logic o_fl_done,
  output logic o_fl_rvalid,
  output logic [7:0] o_fl_rdata
);
  logic [4:0] cnt_reg;
  logic busy_reg;
  logic [1:0] rd_reg;
  // Operation ends after the latency the bench chose
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
      o_fl_done <= 1'b0;
    end else begin
      o_fl_done <= 1'b0;
      if (i_fl_req) begin
        busy_reg <= 1'b1;
        cnt_reg <= i_lat;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg <= 5'h01) begin
          o_fl_done <= 1'b1;
          busy_reg <= 1'b0;
        end
      end
    end
  end
  // Location zero answers two cycles after the read
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_reg <= 2'h0;
    end else begin
      rd_reg <= {rd_reg[0], i_fl_rd};
    end
  end
  assign o_fl_rvalid = rd_reg[1];
  // Inverse byte outside the answer cycle, never a stale copy
  assign o_fl_rdata = o_fl_rvalid ? i_first_byte : ~i_first_byte;
endmodule

/* in_system_flash_programmer_tb_top.sv */
// Self-checking bench of the flash programming sequencer
`timescale 1ns/1ps
`include "isfp_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module in_system_flash_programmer_tb_top;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] i_ext_rdata = 8'h00;
  logic [7:0] boot_byte = 8'hFF;
  logic [3:0] boot_pages = 4'h1;
  logic [4:0] lat = 5'h06;
  logic en = 1'b1, lock_nv = 1'b1, p26 = 1'b1, p27 = 1'b1, p43 = 1'b1;
  logic [7:0] o_sfr_rdata, o_ext_rdata, fl_wdata, fl_rdata;
  logic [15:0] fl_addr, keep_base, boot_vec, base;
  logic [1:0] fl_func;
  logic fl_req, fl_rd, fl_done, fl_rvalid, pc_hold, boot_isp, boot_done, lock;
  logic ul = 1'b0;
  logic [31:0] seed = 32'h000094AB;
  int err_count = 0, n_compared = 0, n_req = 0, cycles = 0;
  logic [1:0] cap_f;
  logic [15:0] cap_a;
  logic [7:0] cap_d;
  // Clock and run limit
  always #2.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (fl_req === 1'b1) begin
      n_req++;
      cap_f = fl_func;
      cap_a = fl_addr;
      cap_d = fl_wdata;
    end
    if (cycles == 30000) begin
      err_count++;
      finish_test();
    end
  end
  isfp_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clk_en(1'b1),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_isp_enable(en),
    .i_boot_pages(boot_pages), .i_prot_lock_nv(lock_nv), .i_p2_6(p26), .i_p2_7(p27),
    .i_p4_3(p43), .o_fl_req(fl_req), .o_fl_func(fl_func), .o_fl_addr(fl_addr),
    .o_fl_wdata(fl_wdata), .o_fl_keep_base(keep_base), .i_fl_done(fl_done),
    .o_fl_rd(fl_rd), .i_fl_rdata(fl_rdata), .i_fl_rvalid(fl_rvalid),
    .i_ext_rdata(i_ext_rdata), .o_ext_rdata(o_ext_rdata), .o_pc_hold(pc_hold),
    .o_boot_isp(boot_isp), .o_boot_vec(boot_vec), .o_boot_done(boot_done));
  isfp_flash_model model (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_fl_req(fl_req),
    .i_fl_rd(fl_rd), .i_first_byte(boot_byte), .i_lat(lat), .o_fl_done(fl_done),
    .o_fl_rvalid(fl_rvalid), .o_fl_rdata(fl_rdata));
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Register write and read cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b0;
    @(posedge i_core_clk);
    #1;
    `CHK(o_sfr_rdata, e)
  endtask
  // Reset with a chosen boot setup, then check the boot decision
  task automatic do_reset(input int b);
    logic isp;
    i_nrst <= 1'b0;
    boot_pages <= 4'(1 + rnd() % 8);
    boot_byte <= (b == 0) ? 8'hFF : 8'(rnd() % 255);
    {p26, p27, p43} <= (b == 1) ? 3'h1 : (b == 2) ? 3'h6 : (b == 0) ? 3'h7 : 3'(rnd());
    lock_nv <= (b == 0) | rnd() % 2;
    cyc(8);
    i_nrst <= 1'b1;
    #1;
    base = 16'h4000 - {3'h0, boot_pages, 9'h000};
    lock = lock_nv;
    ul = 1'b0;
    for (int k = 0; k < 50 && boot_done !== 1'b1; k++) @(posedge i_core_clk);
    #1;
    isp = (boot_byte == 8'hFF) || (!p26 && !p27) || !p43;
    `CHK(boot_done, 1'b1)
    `CHK(boot_isp, isp)
    `CHK(boot_vec, isp ? base : 16'h0000)
    `CHK(keep_base, base)
    for (int a = 8'hF3; a < 8'hF8; a++) chk_rd(8'(a), 8'h00);
  endtask
  // One launch attempt with all its side effects
  task automatic op(input logic [1:0] f, input logic [15:0] ad, input logic [7:0] d,
                    input logic brk);
    logic ex;
    logic go;
    int n0;
    lat <= 5'(6 + rnd() % 20);
    // Key bytes back to back; an open unlock stays open through them
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= `ISFP_OFS_DATA;
    i_sfr_wdata <= `ISFP_KEY_A;
    @(posedge i_core_clk);
    i_sfr_wdata <= `ISFP_KEY_B;
    @(posedge i_core_clk);
    i_sfr_wdata <= brk ? 8'h33 : `ISFP_KEY_A;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
    ul = ul || !brk;
    wr(`ISFP_OFS_ADDR_HI, ad[15:8]);
    wr(`ISFP_OFS_ADDR_LO, ad[7:0]);
    chk_rd(`ISFP_OFS_ADDR_HI, ad[15:8]);
    wr(`ISFP_OFS_DATA, d);
    go = ul && en;
    ex = go && !(f[0] == 1'b0 && ad >= base);
    n0 = n_req;
    wr(`ISFP_OFS_CTRL, {1'b1, 5'h00, f});
    ul = ul && !go;
    #1;
    `CHK(pc_hold, ex)
    if (ex) begin
      chk_rd(`ISFP_OFS_CTRL, {1'b1, 5'h00, f});
      for (int k = 0; k < 64 && pc_hold === 1'b1; k++) @(posedge i_core_clk);
      chk_rd(`ISFP_OFS_CTRL, {6'h00, f});
      `CHK(cap_f, f)
      if (f == isfp_pkg::FN_PAGE_ERASE) `CHK(cap_a, {ad[15:9], 9'h000})
      if (f == isfp_pkg::FN_PROGRAM) `CHK({cap_a, cap_d}, {ad, d})
      if (f == isfp_pkg::FN_PROTECT) lock = 1'b0;
      if (f == isfp_pkg::FN_CHIP_ERASE) lock = 1'b1;
    end else begin
      cyc(4);
    end
    `CHK(n_req, n0 + (ex ? 1 : 0))
    n0 = n_req;
    wr(`ISFP_OFS_CTRL, 8'h80);
    cyc(4);
    `CHK(n_req, n0)
    i_ext_rdata <= 8'(rnd());
    cyc(2);
    #1;
    `CHK(o_ext_rdata, lock ? i_ext_rdata : 8'h00)
  endtask
  // Verdict and end of run
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Boot variants, each followed by corner and random launches
  initial begin
    logic [15:0] ad;
    logic [31:0] r;
    for (int b = 0; b < 6; b++) begin
      do_reset(b);
      for (int j = 0; j < 8; j++) begin
        r = rnd();
        ad = (j == 0) ? base : (j == 1) ? base - 16'h0001 : j[0] ? 16'(r % base) : r[15:0];
        en <= (j != 2);
        op(2'((j + b) % 4), ad, r[23:16], j == 4);
      end
    end
    finish_test();
  end
endmodule
